// ### core/charge_profile_map.svh
// Constants for the thermal charge profile configuration register and its
// serial access path. Included by the package and the design modules.
// What this block does
// - Bits 7:6 scale cool-range fast-charge current
// - Bits 5:4 scale warm-range current, default full
// - Full-current code keeps safety timer normal length
// - Bits 3:2 pick lower normal-range thermal threshold
// - Bits 1:0 pick upper normal-range thermal threshold
// - Register at 0x0c, all bits RW, reset 0x75
// - Reset command restores defaults, then self-clears
`ifndef CHARGE_PROFILE_MAP_SVH
`define CHARGE_PROFILE_MAP_SVH

`define CFG_OFFSET        8'h0c
`define RST_CMD_OFFSET    8'h0b
`define CFG_RESET         8'h75
`define RST_CMD_BIT       7

`define COOL_MSB          7
`define COOL_LSB          6
`define WARM_MSB          5
`define WARM_LSB          4
`define LOWER_MSB         3
`define LOWER_LSB         2
`define UPPER_MSB         1
`define UPPER_LSB         0

`define SCALE_FULL        2'h3

`define PCT_NONE          7'h00
`define PCT_TWENTY        7'h14
`define PCT_FIFTY         7'h32
`define PCT_FULL          7'h64

// Thresholds in hundredths of a percent of the reference
`define LOWER_CODE0       14'h1ba3
`define LOWER_CODE1       14'h1aa9
`define LOWER_CODE2       14'h197d
`define LOWER_CODE3       14'h1851
`define UPPER_CODE0       14'h12d9
`define UPPER_CODE1       14'h117b
`define UPPER_CODE2       14'h0feb
`define UPPER_CODE3       14'h0ebf

// Serial target address; arbitrary value
`define TARGET_ADDR       7'h30
`define BITS_PER_BYTE     4'h8

`endif

// ### core/charge_profile_pkg.sv
// Types and decode functions shared by the configuration modules.
// Assumes charge_profile_map.svh is on the include path.
`include "charge_profile_map.svh"

package charge_profile_pkg;

    typedef enum logic [3:0] {
        st_idle,
        st_addr,
        st_addr_ack,
        st_ptr,
        st_ptr_ack,
        st_wdata,
        st_wdata_ack,
        st_rdata,
        st_rdata_ack
    } serial_state_type;

    function automatic logic [6:0] scale_percent(input logic [1:0] code);
        unique case (code)
            2'h0: scale_percent = `PCT_NONE;
            2'h1: scale_percent = `PCT_TWENTY;
            2'h2: scale_percent = `PCT_FIFTY;
            2'h3: scale_percent = `PCT_FULL;
        endcase
    endfunction

    function automatic logic [13:0] lower_level(input logic [1:0] code);
        unique case (code)
            2'h0: lower_level = `LOWER_CODE0;
            2'h1: lower_level = `LOWER_CODE1;
            2'h2: lower_level = `LOWER_CODE2;
            2'h3: lower_level = `LOWER_CODE3;
        endcase
    endfunction

    function automatic logic [13:0] upper_level(input logic [1:0] code);
        unique case (code)
            2'h0: upper_level = `UPPER_CODE0;
            2'h1: upper_level = `UPPER_CODE1;
            2'h2: upper_level = `UPPER_CODE2;
            2'h3: upper_level = `UPPER_CODE3;
        endcase
    endfunction

endpackage

// ### core/profile_config_reg.sv
// Configuration register with its reset command and field decode.
// Assumes writes arrive as one-cycle strobes from the serial target.
`timescale 1ns/10ps
`include "charge_profile_map.svh"

module profile_config_reg (
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic        wr_en,
    input  wire logic [7:0]  wr_addr,
    input  wire logic [7:0]  wr_data,
    input  wire logic [7:0]  rd_addr,
    input  wire logic        watchdog_expired,
    output logic      [7:0]  rd_data,
    output logic      [1:0]  cool_range_current_scale,
    output logic      [1:0]  warm_range_current_scale,
    output logic      [1:0]  lower_thermal_threshold,
    output logic      [1:0]  upper_thermal_threshold,
    output logic      [6:0]  cool_current_percent,
    output logic      [6:0]  warm_current_percent,
    output logic      [13:0] lower_threshold_level,
    output logic      [13:0] upper_threshold_level,
    output logic             cool_timer_normal,
    output logic             warm_timer_normal,
    output logic             safety_timer_reset
);
    import charge_profile_pkg::*;

    logic [7:0] cfg_reg;
    logic [7:0] cfg_next;
    logic       rst_cmd_reg;
    logic       rst_cmd_next;
    logic       timer_rst_reg;

    wire cfg_hit     = wr_en && (wr_addr == `CFG_OFFSET);
    wire cmd_hit     = wr_en && (wr_addr == `RST_CMD_OFFSET);
    wire cmd_set     = cmd_hit && wr_data[`RST_CMD_BIT];
    wire to_defaults = rst_cmd_reg || watchdog_expired;

    // Defaults beat a same-cycle host write to this register
    assign cfg_next = to_defaults ? `CFG_RESET :
                      cfg_hit     ? wr_data : cfg_reg;
    // A new command in the clearing cycle stays pending
    assign rst_cmd_next = cmd_set;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cfg_reg       <= `CFG_RESET;
            rst_cmd_reg   <= 1'b0;
            timer_rst_reg <= 1'b0;
        end else begin
            cfg_reg       <= cfg_next;
            rst_cmd_reg   <= rst_cmd_next;
            timer_rst_reg <= rst_cmd_reg;
        end
    end

    assign rd_data = (rd_addr == `CFG_OFFSET)     ? cfg_reg :
                     (rd_addr == `RST_CMD_OFFSET) ?
                         {rst_cmd_reg, 7'h00} : 8'h00;

    assign cool_range_current_scale = cfg_reg[`COOL_MSB:`COOL_LSB];
    assign warm_range_current_scale = cfg_reg[`WARM_MSB:`WARM_LSB];
    assign lower_thermal_threshold  = cfg_reg[`LOWER_MSB:`LOWER_LSB];
    assign upper_thermal_threshold  = cfg_reg[`UPPER_MSB:`UPPER_LSB];
    assign cool_current_percent  = scale_percent(cool_range_current_scale);
    assign warm_current_percent  = scale_percent(warm_range_current_scale);
    assign lower_threshold_level = lower_level(lower_thermal_threshold);
    assign upper_threshold_level = upper_level(upper_thermal_threshold);
    assign cool_timer_normal =
        (cool_range_current_scale == `SCALE_FULL);
    assign warm_timer_normal =
        (warm_range_current_scale == `SCALE_FULL);
    assign safety_timer_reset = timer_rst_reg;

endmodule

// ### core/charge_profile_target.sv
// Two-wire serial target giving the host access to the charge profile
// configuration register. Assumes scl_in and sda_in are already synchronous
// to mclk and that mclk is far faster than the serial bit rate.
`timescale 1ns/10ps
`include "charge_profile_map.svh"

module charge_profile_target (
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    input  wire logic        watchdog_expired,
    output logic      [1:0]  cool_range_current_scale,
    output logic      [1:0]  warm_range_current_scale,
    output logic      [1:0]  lower_thermal_threshold,
    output logic      [1:0]  upper_thermal_threshold,
    output logic      [6:0]  cool_current_percent,
    output logic      [6:0]  warm_current_percent,
    output logic      [13:0] lower_threshold_level,
    output logic      [13:0] upper_threshold_level,
    output logic             cool_timer_normal,
    output logic             warm_timer_normal,
    output logic             safety_timer_reset
);
    import charge_profile_pkg::*;

    serial_state_type state_reg;
    serial_state_type state_next;
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    logic [7:0] tx_reg;
    logic [7:0] tx_next;
    logic [7:0] ptr_reg;
    logic [7:0] ptr_next;
    logic       nack_reg;
    logic       nack_next;
    logic       oe_reg;
    logic       oe_next;
    logic       scl_prev_reg;
    logic       sda_prev_reg;
    logic       wr_en;
    logic [7:0] rd_data;

    wire scl_rise  = scl_in && !scl_prev_reg;
    wire scl_fall  = !scl_in && scl_prev_reg;
    wire start_seen = scl_in && scl_prev_reg && sda_prev_reg && !sda_in;
    wire stop_seen  = scl_in && scl_prev_reg && !sda_prev_reg && sda_in;
    wire byte_done = (cnt_reg == `BITS_PER_BYTE);
    wire addr_match = (shift_reg[7:1] == `TARGET_ADDR);
    wire receiving = (state_reg == st_addr) || (state_reg == st_ptr) ||
                     (state_reg == st_wdata);
    wire [7:0] ptr_inc = ptr_reg + 8'h01;
    wire [2:0] tx_index = 3'h7 - cnt_reg[2:0];

    // Read data follow the pointer at the moment a byte is launched
    wire [7:0] rd_addr = (state_reg == st_rdata_ack) ? ptr_inc : ptr_reg;

    assign wr_en = scl_fall && (state_reg == st_wdata) && byte_done;

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        shift_next = shift_reg;
        tx_next    = tx_reg;
        ptr_next   = ptr_reg;
        nack_next  = nack_reg;
        oe_next    = oe_reg;
        if (start_seen) begin
            state_next = st_addr;
            cnt_next   = 4'h0;
            oe_next    = 1'b0;
        end else if (stop_seen) begin
            state_next = st_idle;
            oe_next    = 1'b0;
        end else if (scl_rise) begin
            if (receiving) begin
                shift_next = {shift_reg[6:0], sda_in};
                cnt_next   = cnt_reg + 4'h1;
            end else if (state_reg == st_rdata) begin
                cnt_next   = cnt_reg + 4'h1;
            end else if (state_reg == st_rdata_ack) begin
                nack_next  = sda_in;
            end
        end else if (scl_fall) begin
            unique case (state_reg)
                st_idle: begin
                    oe_next = 1'b0;
                end
                st_addr: begin
                    if (byte_done) begin
                        cnt_next   = 4'h0;
                        oe_next    = addr_match;
                        state_next = addr_match ? st_addr_ack : st_idle;
                    end
                end
                st_addr_ack: begin
                    cnt_next = 4'h0;
                    if (shift_reg[0]) begin
                        tx_next    = rd_data;
                        oe_next    = !rd_data[7];
                        state_next = st_rdata;
                    end else begin
                        oe_next    = 1'b0;
                        state_next = st_ptr;
                    end
                end
                st_ptr: begin
                    if (byte_done) begin
                        ptr_next   = shift_reg;
                        cnt_next   = 4'h0;
                        oe_next    = 1'b1;
                        state_next = st_ptr_ack;
                    end
                end
                st_ptr_ack: begin
                    oe_next    = 1'b0;
                    state_next = st_wdata;
                end
                st_wdata: begin
                    if (byte_done) begin
                        ptr_next   = ptr_inc;
                        cnt_next   = 4'h0;
                        oe_next    = 1'b1;
                        state_next = st_wdata_ack;
                    end
                end
                st_wdata_ack: begin
                    oe_next    = 1'b0;
                    state_next = st_wdata;
                end
                st_rdata: begin
                    if (byte_done) begin
                        oe_next    = 1'b0;
                        state_next = st_rdata_ack;
                    end else begin
                        oe_next = !tx_reg[tx_index];
                    end
                end
                st_rdata_ack: begin
                    // Host NACK ends the read; the line is released
                    cnt_next = 4'h0;
                    if (nack_reg) begin
                        oe_next    = 1'b0;
                        state_next = st_idle;
                    end else begin
                        ptr_next   = ptr_inc;
                        tx_next    = rd_data;
                        oe_next    = !rd_data[7];
                        state_next = st_rdata;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_reg    <= st_idle;
            cnt_reg      <= 4'h0;
            shift_reg    <= 8'h00;
            tx_reg       <= 8'h00;
            ptr_reg      <= 8'h00;
            nack_reg     <= 1'b0;
            oe_reg       <= 1'b0;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            shift_reg    <= shift_next;
            tx_reg       <= tx_next;
            ptr_reg      <= ptr_next;
            nack_reg     <= nack_next;
            oe_reg       <= oe_next;
            scl_prev_reg <= scl_in;
            sda_prev_reg <= sda_in;
        end
    end

    // Open drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe  = oe_reg;

    profile_config_reg u_cfg (
        .mclk                     (mclk),
        .nrst                     (nrst),
        .wr_en                    (wr_en),
        .wr_addr                  (ptr_reg),
        .wr_data                  (shift_reg),
        .rd_addr                  (rd_addr),
        .watchdog_expired         (watchdog_expired),
        .rd_data                  (rd_data),
        .cool_range_current_scale (cool_range_current_scale),
        .warm_range_current_scale (warm_range_current_scale),
        .lower_thermal_threshold  (lower_thermal_threshold),
        .upper_thermal_threshold  (upper_thermal_threshold),
        .cool_current_percent     (cool_current_percent),
        .warm_current_percent     (warm_current_percent),
        .lower_threshold_level    (lower_threshold_level),
        .upper_threshold_level    (upper_threshold_level),
        .cool_timer_normal        (cool_timer_normal),
        .warm_timer_normal        (warm_timer_normal),
        .safety_timer_reset       (safety_timer_reset)
    );

endmodule

// ### tb/profile_monitor.sv
// Checker on the charge profile target ports, bound to the top module.
// Assumes one clock, mclk, and an asynchronous active-low nrst.
`timescale 1ns/10ps

module profile_monitor (
    input wire logic        mclk,
    input wire logic        nrst,
    input wire logic        scl_in,
    input wire logic        watchdog_expired,
    input wire logic [1:0]  cool_range_current_scale,
    input wire logic [1:0]  warm_range_current_scale,
    input wire logic [1:0]  lower_thermal_threshold,
    input wire logic [1:0]  upper_thermal_threshold,
    input wire logic [6:0]  cool_current_percent,
    input wire logic [6:0]  warm_current_percent,
    input wire logic [13:0] lower_threshold_level,
    input wire logic [13:0] upper_threshold_level,
    input wire logic        cool_timer_normal,
    input wire logic        warm_timer_normal,
    input wire logic        safety_timer_reset
);
    localparam logic [6:0] pct [4] = '{7'h00, 7'h14, 7'h32, 7'h64};
    localparam logic [13:0] lo [4] = '{14'h1ba3, 14'h1aa9, 14'h197d, 14'h1851};
    localparam logic [13:0] up [4] = '{14'h12d9, 14'h117b, 14'h0feb, 14'h0ebf};
    logic [7:0] cfg;
    logic       scl_d;
    logic [2:0] fall_age;
    assign cfg = {cool_range_current_scale, warm_range_current_scale,
                  lower_thermal_threshold, upper_thermal_threshold};
    // Writes land just after an SCL fall; age saturates to stay small
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            scl_d    <= 1'b1;
            fall_age <= 3'h7;
        end else begin
            scl_d <= scl_in;
            if (scl_d && !scl_in)
                fall_age <= 3'h0;
            else if (fall_age != 3'h7)
                fall_age <= fall_age + 3'h1;
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    a_cool_pct: assert property (
        cool_current_percent == pct[cool_range_current_scale])
        else $error("cool percent wrong");
    a_warm_pct: assert property (
        warm_current_percent == pct[warm_range_current_scale])
        else $error("warm percent wrong");
    a_cool_timer: assert property (
        cool_timer_normal == (cool_range_current_scale == 2'h3))
        else $error("cool timer flag wrong");
    a_warm_timer: assert property (
        warm_timer_normal == (warm_range_current_scale == 2'h3))
        else $error("warm timer flag wrong");
    a_lower_level: assert property (
        lower_threshold_level == lo[lower_thermal_threshold])
        else $error("lower level wrong");
    a_upper_level: assert property (
        upper_threshold_level == up[upper_thermal_threshold])
        else $error("upper level wrong");
    a_cfg_cause: assert property (
        $changed(cfg) |-> $past(watchdog_expired) || fall_age < 3'h4)
        else $error("register changed without cause");
    a_cmd_pulse: assert property (
        safety_timer_reset |-> cfg == 8'h75 ##1 !safety_timer_reset)
        else $error("timer reset pulse wrong");
    a_wdog_default: assert property (
        watchdog_expired |=> cfg == 8'h75)
        else $error("watchdog did not restore");
    c_wdog: cover property (watchdog_expired);
    c_cmd: cover property (safety_timer_reset);
    c_full: cover property (cool_timer_normal ##1 !cool_timer_normal);
endmodule

bind charge_profile_target profile_monitor u_profile_monitor (
    .mclk, .nrst, .scl_in, .watchdog_expired,
    .cool_range_current_scale, .warm_range_current_scale,
    .lower_thermal_threshold, .upper_thermal_threshold,
    .cool_current_percent, .warm_current_percent,
    .lower_threshold_level, .upper_threshold_level,
    .cool_timer_normal, .warm_timer_normal, .safety_timer_reset);

// ### tb/host_model.sv
// Host on the two-wire link: drives SCL and its own side of SDA.
// Assumes the bench resolves SDA with a pull-up, the device pulling low.
`timescale 1ns/10ps

module host_model (
    input  wire logic mclk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_h
);
    logic [7:0] nak_cnt;
    initial begin
        scl     = 1'b1;
        sda_h   = 1'b1;
        nak_cnt = 8'h00;
    end
    // Four mclk per phase, four times the shortest phase the target takes
    task automatic set(input logic c, input logic d);
        scl   = c;
        sda_h = d;
        repeat (4) @(negedge mclk);
    endtask
    task automatic bit_io(input logic b, output logic r);
        set(1'b0, b);
        set(1'b1, b);
        r = sda;
        set(1'b0, b);
    endtask
    task automatic start();
        set(scl, 1'b1);
        set(1'b1, 1'b1);
        set(1'b1, 1'b0);
        set(1'b0, 1'b0);
    endtask
    task automatic stop();
        set(1'b0, 1'b0);
        set(1'b1, 1'b0);
        set(1'b1, 1'b1);
    endtask
    task automatic xfer(input logic [7:0] d, input logic nine,
                        output logic [7:0] q, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(nine, a);
        ack = !a;
    endtask
    task automatic put(input logic [7:0] d);
        logic [7:0] q;
        logic       a;
        xfer(d, 1'b1, q, a);
        if (!a)
            nak_cnt++;
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        start();
        put(8'h60);
        put(p);
        put(d);
        stop();
    endtask
    task automatic rd(input logic [7:0] p, output logic [7:0] d);
        logic a;
        start();
        put(8'h60);
        put(p);
        start();
        put(8'h61);
        // Released ninth bit is the NACK that ends the read
        xfer(8'hff, 1'b1, d, a);
        stop();
    endtask
endmodule

// ### tb/tb.sv
// Bench for the charge profile target: host writes, reads and resets.
// Assumes host_model and the bound profile_monitor are compiled first.
`timescale 1ns/10ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin \
    err_count++; $display("wrong value at %0t: %h vs %h", $time, a, e); \
    end end

module tb;
    typedef struct packed {
        logic [7:0]  v;
        logic [6:0]  cp;
        logic [6:0]  wp;
        logic [13:0] lo;
        logic [13:0] up;
        logic        ct;
        logic        wt;
    } row_type;
    localparam row_type rows [4] = '{
        '{8'h1b, 7'h00, 7'h14, 14'h197d, 14'h0ebf, 1'b0, 1'b0},
        '{8'he4, 7'h64, 7'h32, 14'h1aa9, 14'h12d9, 1'b1, 1'b0},
        '{8'h4e, 7'h14, 7'h00, 14'h1851, 14'h0feb, 1'b0, 1'b0},
        '{8'hb1, 7'h32, 7'h64, 14'h1ba3, 14'h117b, 1'b0, 1'b1}};
    logic        mclk = 1'b0;
    logic        nrst = 1'b0;
    logic        wdog = 1'b0;
    logic        scl, sda_h, sda_out, sda_oe, ct, wt, str, a;
    logic [1:0]  cs, ws, ls, us;
    logic [6:0]  cp, wp;
    logic [13:0] ll, ul;
    logic [7:0]  d;
    logic [7:0]  n_pulse = 8'h00;
    int          err_count = 0;
    int          n_compared = 0;
    int          cyc = 0;
    wire  [7:0]  cfg = {cs, ws, ls, us};
    wire         sda = sda_h & (sda_oe ? sda_out : 1'b1);
    always #12.5 mclk = ~mclk;
    charge_profile_target u_charge_profile_target (
        .mclk(mclk), .nrst(nrst), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .watchdog_expired(wdog),
        .cool_range_current_scale(cs), .warm_range_current_scale(ws),
        .lower_thermal_threshold(ls), .upper_thermal_threshold(us),
        .cool_current_percent(cp), .warm_current_percent(wp),
        .lower_threshold_level(ll), .upper_threshold_level(ul),
        .cool_timer_normal(ct), .warm_timer_normal(wt),
        .safety_timer_reset(str));
    host_model u_host_model (
        .mclk(mclk), .sda(sda), .scl(scl), .sda_h(sda_h));
    task automatic finish_test();
        $display("compared %0d, wrong %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Ceiling far above the seven thousand or so cycles the tests take
    always @(posedge mclk) begin
        cyc++;
        if (str === 1'b1)
            n_pulse++;
        if (cyc == 40000) begin
            err_count++;
            finish_test();
        end
    end
    initial begin
        repeat (2) @(negedge mclk);
        nrst = 1'b1;
        foreach (rows[i]) begin
            u_host_model.wr(8'h0c, rows[i].v);
            `CHK(cfg, rows[i].v)
            `CHK(cp, rows[i].cp)
            `CHK(wp, rows[i].wp)
            `CHK(ct, rows[i].ct)
            `CHK(wt, rows[i].wt)
            `CHK(ll, rows[i].lo)
            `CHK(ul, rows[i].up)
            u_host_model.rd(8'h0c, d);
            `CHK(d, rows[i].v)
        end
        $display("test rows done");
        u_host_model.wr(8'h0b, 8'h80);
        `CHK(cfg, 8'h75)
        `CHK(n_pulse, 8'h01)
        u_host_model.rd(8'h0b, d);
        `CHK(d, 8'h00)
        $display("test register reset done");
        u_host_model.wr(8'h0c, 8'h00);
        wdog = 1'b1;
        @(negedge mclk);
        wdog = 1'b0;
        @(negedge mclk);
        `CHK(cfg, 8'h75)
        `CHK(n_pulse, 8'h01)
        $display("test watchdog done");
        u_host_model.start();
        u_host_model.xfer(8'h62, 1'b1, d, a);
        u_host_model.stop();
        `CHK(a, 1'b0)
        u_host_model.wr(8'h0d, 8'h00);
        `CHK(cfg, 8'h75)
        u_host_model.rd(8'h0d, d);
        `CHK(d, 8'h00)
        `CHK(u_host_model.nak_cnt, 8'h00)
        $display("test refusal done");
        // Pointer must step on per byte in both directions
        u_host_model.start();
        u_host_model.put(8'h60);
        u_host_model.put(8'h0b);
        u_host_model.put(8'h00);
        u_host_model.put(8'ha5);
        u_host_model.stop();
        `CHK(cfg, 8'ha5)
        `CHK(n_pulse, 8'h01)
        u_host_model.start();
        u_host_model.put(8'h60);
        u_host_model.put(8'h0b);
        u_host_model.start();
        u_host_model.put(8'h61);
        u_host_model.xfer(8'hff, 1'b0, d, a);
        `CHK(d, 8'h00)
        u_host_model.xfer(8'hff, 1'b1, d, a);
        u_host_model.stop();
        `CHK(d, 8'ha5)
        `CHK(u_host_model.nak_cnt, 8'h00)
        $display("test burst done");
        u_host_model.wr(8'h0c, 8'h00);
        nrst = 1'b0;
        #1;
        `CHK(cfg, 8'h75)
        repeat (2) @(negedge mclk);
        nrst = 1'b1;
        u_host_model.rd(8'h0c, d);
        `CHK(d, 8'h75)
        $display("test reset done");
        finish_test();
    end
endmodule
